// File: logic/scr_command_regs.sv
`timescale 1ns/10ps
// Functional notes
// - act on a write frame only if its CRC byte matches; else drop and flag error
// - self-test field write honoured only in standby state
// - restart, force and forced address writes honoured only in second init state
// - registers decode at 1C, 1D, 1E; other offsets reserved
// - slew code in bits 15-13, both outputs, resets to 4
// - bit 12 skips the retry wait
// - bits 11 and 10 skip peak cycle for outputs 1 and 2
// - self-test: 1 fault pin low, 2 timeout until clear, 3 gives 10 kHz clock
// - fault clear bit pulses clear and returns to zero by itself
// - action bit 14 locks configuration
// - duty mode: 0-1 off, 2 regulate, 3-7 fixed duty
// - frequency mode: 0-1 off, 2-7 fixed 20 to 10 kHz at 25 percent
// - drive codes 2-7 only valid while step field is not 4
// - broadcast applied by all; only matching node drives serial output
// - broadcast bit 14 restarts node address determination
// - bit 13 with address error and no restart adopts bits 12-11
// - step field moves both targets of each output on drive code 2 in duty mode by 16, 32, 64 (codes 1-3 up, 5-7 down) with saturation at 00h and FFh
// - step code 4 shuts both outputs off
// - reset values 8000h, 0000h, 0000h
// - mode bit selects duty or frequency reading of drive codes
module scr_command_regs (
  // ****************************************
  // clock and reset
  // ****************************************
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // ****************************************
  // deserialised frame
  // ****************************************
  input  wire logic             frame_valid,
  input  wire logic             frame_write,
  input  wire logic [4:0]       frame_addr,
  input  wire logic [1:0]       frame_node,
  input  wire logic [15:0]      frame_payload,
  input  wire logic [7:0]       frame_crc,
  output logic      [15:0]      read_data,
  output logic                  read_valid,
  output logic                  sdo_drive_en,
  output logic                  spi_error,
  // ****************************************
  // device state
  // ****************************************
  input  wire logic             in_standby,
  input  wire logic             second_init_state,
  input  wire logic [1:0]       node_address,
  input  wire logic             address_error_flag,
  input  wire logic             address_restart_flag,
  input  wire logic             out1_drive_mode_sel,
  input  wire logic             out2_drive_mode_sel,
  input  wire logic [1:0][7:0]  peak_target,
  input  wire logic [1:0][7:0]  hold_target,
  // ****************************************
  // general controls
  // ****************************************
  output logic      [2:0]       output_slew_select,
  output logic                  retry_delay_skip,
  output logic                  out1_peak_skip,
  output logic                  out2_peak_skip,
  output logic                  fault_pin_n_force_low,
  output logic                  test_timeout_force,
  output logic                  test_clk_out,
  output logic                  fault_clear,
  output logic                  config_lock,
  // ****************************************
  // node address control
  // ****************************************
  output logic                  address_restart,
  output logic                  address_force,
  output logic      [1:0]       forced_address_value,
  // ****************************************
  // drive outputs
  // ****************************************
  output logic      [1:0]       out_enable,
  output logic      [1:0]       out_regulate,
  output logic      [1:0]       out_freq_mode,
  output logic      [1:0][6:0]  out_duty_pct,
  output logic      [1:0][4:0]  pwm_centre_freq,
  output logic                  target_load,
  output logic      [1:0][7:0]  peak_target_new,
  output logic      [1:0][7:0]  hold_target_new
);
  // ****************************************
  // frame check
  // ****************************************
  logic [7:0] crc_calc;
  logic       crc_ok;
  logic       wr_ok;
  logic       wr_gen;
  logic       wr_act;
  logic       wr_bc;

  scr_crc8 #(
    .POLY (scr_pkg::CRC_POLY),
    .INIT (scr_pkg::CRC_INIT)
  ) u_crc (
    .data (frame_payload),
    .crc  (crc_calc)
  );

  assign crc_ok = (crc_calc == frame_crc);
  assign wr_ok  = frame_valid && frame_write && crc_ok;
  assign wr_gen = wr_ok && (frame_addr == scr_pkg::GEN_ADDR);
  assign wr_act = wr_ok && (frame_addr == scr_pkg::ACT_ADDR);
  assign wr_bc  = wr_ok && (frame_addr == scr_pkg::BC_ADDR);

  // ****************************************
  // drive decode
  // ****************************************
  function automatic logic [15:0] drv_decode(input logic mode, input logic [2:0] code, input logic shut);
    logic [6:0] duty;
    logic [4:0] freq;
    logic       en;
    logic       reg_on;
    duty   = 7'h00;
    freq   = 5'h00;
    en     = 1'b0;
    reg_on = 1'b0;
    if (!shut && code >= 3'h2) begin
      en = 1'b1;
      if (mode) begin
        duty = 7'h19;
        case (code)
          3'h2:    freq = 5'h14;
          3'h3:    freq = 5'h12;
          3'h4:    freq = 5'h10;
          3'h5:    freq = 5'h0E;
          3'h6:    freq = 5'h0C;
          default: freq = 5'h0A;
        endcase
      end else begin
        case (code)
          3'h2:    reg_on = 1'b1;
          3'h3:    duty = 7'h64;
          3'h4:    duty = 7'h4B;
          3'h5:    duty = 7'h32;
          3'h6:    duty = 7'h19;
          default: duty = 7'h00;
        endcase
      end
    end
    drv_decode = {en, reg_on, mode, duty, freq[4:0], 1'b0};
  endfunction

  function automatic logic [7:0] step_target(input logic [7:0] v, input logic [2:0] code);
    logic [8:0] sum;
    logic [7:0] amt;
    sum = 9'h000;
    amt = (code[1:0] == 2'h1) ? 8'h10 : (code[1:0] == 2'h2) ? 8'h20 : 8'h40;
    if (code == 3'h0 || code == scr_pkg::STEP_SHUT) begin
      step_target = v;
    end else if (!code[2]) begin
      sum = {1'b0, v} + {1'b0, amt};
      step_target = sum[8] ? scr_pkg::TARGET_MAX : sum[7:0];
    end else begin
      step_target = (v > amt) ? 8'(v - amt) : 8'h00;
    end
  endfunction

  // ****************************************
  // register state
  // ****************************************
  logic [15:0]      gen_r, gen_nxt;
  logic [15:0]      act_r, act_nxt;
  logic [15:0]      bc_r, bc_nxt;
  logic             st_fault_r, st_fault_nxt;
  logic             st_tmo_r, st_tmo_nxt;
  logic             fclr_r, fclr_nxt;
  logic             rstrt_r, rstrt_nxt;
  logic             force_r, force_nxt;
  logic [1:0]       fadr_r, fadr_nxt;
  logic [15:0]      rd_r, rd_nxt;
  logic             rdv_r, rdv_nxt;
  logic             sdo_r, sdo_nxt;
  logic             err_r, err_nxt;
  logic             tload_r, tload_nxt;
  logic [1:0][7:0]  pk_r, pk_nxt;
  logic [1:0][7:0]  hd_r, hd_nxt;
  logic [1:0][15:0] drv_r, drv_nxt;
  logic [9:0]       tcnt_r, tcnt_nxt;
  logic             tclk_r, tclk_nxt;
  logic [1:0]       mode_sel;
  logic [2:0]       step_code;

  assign mode_sel = {out2_drive_mode_sel, out1_drive_mode_sel};

  always_comb begin
    gen_nxt      = gen_r;
    act_nxt      = act_r;
    bc_nxt       = bc_r;
    act_nxt[scr_pkg::FCLR_BIT] = 1'b0;
    bc_nxt[scr_pkg::FCLR_BIT]  = 1'b0;
    st_fault_nxt = st_fault_r;
    st_tmo_nxt   = st_tmo_r;
    fclr_nxt     = 1'b0;
    rstrt_nxt    = 1'b0;
    force_nxt    = 1'b0;
    fadr_nxt     = fadr_r;
    err_nxt      = frame_valid && frame_write && !crc_ok;
    rdv_nxt      = frame_valid && !frame_write;
    sdo_nxt      = frame_valid && (frame_node == node_address);
    rd_nxt       = rd_r;
    tload_nxt    = 1'b0;
    pk_nxt       = pk_r;
    hd_nxt       = hd_r;
    step_code    = frame_payload[scr_pkg::STEP_HI:scr_pkg::STEP_LO];
    if (frame_valid && !frame_write) begin
      case (frame_addr)
        scr_pkg::GEN_ADDR: rd_nxt = gen_r;
        scr_pkg::ACT_ADDR: rd_nxt = act_r;
        scr_pkg::BC_ADDR:  rd_nxt = bc_r;
        default:           rd_nxt = 16'h0000;
      endcase
    end
    if (wr_gen) begin
      gen_nxt[15:10] = frame_payload[15:10];
      if (in_standby) begin
        gen_nxt[scr_pkg::TEST_HI:scr_pkg::TEST_LO] = frame_payload[scr_pkg::TEST_HI:scr_pkg::TEST_LO];
        if (frame_payload[scr_pkg::TEST_HI:scr_pkg::TEST_LO] == scr_pkg::TEST_FAULT_LOW) begin
          st_fault_nxt = 1'b1;
        end
        if (frame_payload[scr_pkg::TEST_HI:scr_pkg::TEST_LO] == scr_pkg::TEST_TIMEOUT) begin
          st_tmo_nxt = 1'b1;
        end
      end
    end
    if (wr_act) begin
      act_nxt[15:8] = frame_payload[15:8];
    end
    if (wr_bc) begin
      bc_nxt[scr_pkg::FCLR_BIT] = frame_payload[scr_pkg::FCLR_BIT];
      bc_nxt[scr_pkg::STEP_HI:scr_pkg::STEP_LO] = step_code;
      if (second_init_state) begin
        bc_nxt[14:11] = frame_payload[14:11];
        rstrt_nxt = frame_payload[scr_pkg::RSTRT_BIT];
        if (frame_payload[scr_pkg::FORCE_BIT] && address_error_flag && !address_restart_flag) begin
          force_nxt = 1'b1;
          fadr_nxt  = frame_payload[scr_pkg::FADR_HI:scr_pkg::FADR_LO];
        end
      end
      if (step_code != 3'h0 && step_code != scr_pkg::STEP_SHUT) begin
        for (int i = 0; i < 2; i++) begin
          if (!mode_sel[i] && act_r[scr_pkg::DRV1_HI - 3 * i -: 3] == scr_pkg::DRV_REGULATE) begin
            pk_nxt[i] = step_target(peak_target[i], step_code);
            hd_nxt[i] = step_target(hold_target[i], step_code);
            tload_nxt = 1'b1;
          end
        end
      end
    end
    if ((wr_act || wr_bc) && frame_payload[scr_pkg::FCLR_BIT]) begin
      fclr_nxt = 1'b1;
    end
    if (fclr_r) begin
      st_fault_nxt = 1'b0;
      st_tmo_nxt   = 1'b0;
      if (wr_gen && in_standby) begin
        st_fault_nxt = frame_payload[scr_pkg::TEST_HI:scr_pkg::TEST_LO] == scr_pkg::TEST_FAULT_LOW;
        st_tmo_nxt   = frame_payload[scr_pkg::TEST_HI:scr_pkg::TEST_LO] == scr_pkg::TEST_TIMEOUT;
      end
    end
    for (int i = 0; i < 2; i++) begin
      drv_nxt[i] = drv_decode(mode_sel[i], act_nxt[scr_pkg::DRV1_HI - 3 * i -: 3],
                              bc_nxt[scr_pkg::STEP_HI:scr_pkg::STEP_LO] == scr_pkg::STEP_SHUT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gen_r      <= scr_pkg::GEN_RESET;
      act_r      <= scr_pkg::ACT_RESET;
      bc_r       <= scr_pkg::BC_RESET;
      st_fault_r <= 1'b0;
      st_tmo_r   <= 1'b0;
      fclr_r     <= 1'b0;
      rstrt_r    <= 1'b0;
      force_r    <= 1'b0;
      fadr_r     <= 2'h0;
      rd_r       <= 16'h0000;
      rdv_r      <= 1'b0;
      sdo_r      <= 1'b0;
      err_r      <= 1'b0;
      tload_r    <= 1'b0;
      pk_r       <= '0;
      hd_r       <= '0;
      drv_r      <= '0;
    end else begin
      gen_r      <= gen_nxt;
      act_r      <= act_nxt;
      bc_r       <= bc_nxt;
      st_fault_r <= st_fault_nxt;
      st_tmo_r   <= st_tmo_nxt;
      fclr_r     <= fclr_nxt;
      rstrt_r    <= rstrt_nxt;
      force_r    <= force_nxt;
      fadr_r     <= fadr_nxt;
      rd_r       <= rd_nxt;
      rdv_r      <= rdv_nxt;
      sdo_r      <= sdo_nxt;
      err_r      <= err_nxt;
      tload_r    <= tload_nxt;
      pk_r       <= pk_nxt;
      hd_r       <= hd_nxt;
      drv_r      <= drv_nxt;
    end
  end

  // ****************************************
  // self-test clock divider
  // ****************************************
  always_comb begin
    tcnt_nxt = 10'h000;
    tclk_nxt = 1'b0;
    if (gen_r[scr_pkg::TEST_HI:scr_pkg::TEST_LO] == scr_pkg::TEST_CLOCK) begin
      tcnt_nxt = (tcnt_r == scr_pkg::TEST_HALF_LAST) ? 10'h000 : tcnt_r + 10'h001;
      tclk_nxt = (tcnt_r == scr_pkg::TEST_HALF_LAST) ? !tclk_r : tclk_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tcnt_r <= 10'h000;
      tclk_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      tclk_r <= tclk_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign read_data             = rd_r;
  assign read_valid            = rdv_r;
  assign sdo_drive_en          = sdo_r;
  assign spi_error             = err_r;
  assign output_slew_select    = gen_r[scr_pkg::SLEW_HI:scr_pkg::SLEW_LO];
  assign retry_delay_skip      = gen_r[scr_pkg::RETRY_BIT];
  assign out1_peak_skip        = gen_r[scr_pkg::SKIP1_BIT];
  assign out2_peak_skip        = gen_r[scr_pkg::SKIP2_BIT];
  assign fault_pin_n_force_low = st_fault_r;
  assign test_timeout_force    = st_tmo_r;
  assign test_clk_out          = tclk_r;
  assign fault_clear           = fclr_r;
  assign config_lock           = act_r[scr_pkg::LOCK_BIT];
  assign address_restart       = rstrt_r;
  assign address_force         = force_r;
  assign forced_address_value  = fadr_r;
  assign target_load           = tload_r;
  assign peak_target_new       = pk_r;
  assign hold_target_new       = hd_r;
  for (genvar g = 0; g < 2; g++) begin : g_drv
    assign out_enable[g]      = drv_r[g][15];
    assign out_regulate[g]    = drv_r[g][14];
    assign out_freq_mode[g]   = drv_r[g][13];
    assign out_duty_pct[g]    = drv_r[g][12:6];
    assign pwm_centre_freq[g] = drv_r[g][5:1];
  end

  // ****************************************
  // assertions
  // ****************************************
  a_bad_crc_drop: assert property (@(posedge ref_clk) disable iff (reset)
    frame_valid && frame_write && !crc_ok |=> spi_error && gen_r == $past(gen_r) && act_r[14:8] == $past(act_r[14:8]))
    else $error("bad crc frame changed state");
  a_test_gate: assert property (@(posedge ref_clk) disable iff (reset)
    wr_gen && !in_standby |=> gen_r[9:8] == $past(gen_r[9:8]) && !$rose(st_fault_r))
    else $error("self-test written outside standby");
  a_second_init_state_gate: assert property (@(posedge ref_clk) disable iff (reset)
    wr_bc && !second_init_state |=> bc_r[14:11] == $past(bc_r[14:11]) && !address_restart && !address_force)
    else $error("address field written outside second_init_state");
  a_fclr_self: assert property (@(posedge ref_clk) disable iff (reset)
    wr_act && frame_payload[15] |=> fault_clear && act_r[15]
    ##1 (!fault_clear || $past(fclr_nxt)) && (!act_r[15] || $past(wr_act)))
    else $error("fault clear not pulsed and self cleared");
  a_shut_both: assert property (@(posedge ref_clk) disable iff (reset)
    bc_r[10:8] == 3'h4 |-> out_enable == 2'b00)
    else $error("outputs on while shut code held");
  a_drive_reg: assert property (@(posedge ref_clk) disable iff (reset)
    $past(act_r[13:11]) == 3'h2 && act_r[13:11] == 3'h2 && !out1_drive_mode_sel && !$past(out1_drive_mode_sel)
    && bc_r[10:8] != 3'h4 |-> out_enable[0] && out_regulate[0])
    else $error("code 2 did not regulate output 1");
  a_step_up: assert property (@(posedge ref_clk) disable iff (reset)
    wr_bc && frame_payload[10:8] == 3'h1 && act_r[13:11] == 3'h2 && !out1_drive_mode_sel
    |=> target_load && peak_target_new[0] == (($past(peak_target[0]) > 8'hEF) ? 8'hFF : $past(peak_target[0]) + 8'h10))
    else $error("step up wrong");
  a_sdo_match: assert property (@(posedge ref_clk) disable iff (reset)
    sdo_drive_en |-> $past(frame_node) == $past(node_address) && $past(frame_valid))
    else $error("serial output driven for other node");
  a_slew_reset: assert property (@(posedge ref_clk)
    $fell(reset) |-> output_slew_select == 3'h4 && act_r == 16'h0000 && bc_r == 16'h0000)
    else $error("wrong reset values");
endmodule

// File: logic/scr_crc8.sv
`timescale 1ns/10ps
module scr_crc8 #(
  parameter logic [7:0] POLY = 8'h2F,
  parameter logic [7:0] INIT = 8'hFF
) (
  // ****************************************
  // frame bytes
  // ****************************************
  input  wire logic [15:0] data,
  // ****************************************
  // result
  // ****************************************
  output logic      [7:0]  crc
);
  always_comb begin
    logic [7:0] c;
    c = INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc = c;
  end
endmodule

// File: logic/scr_pkg.sv
package scr_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [4:0] GEN_ADDR = 5'h1C;
  localparam logic [4:0] ACT_ADDR = 5'h1D;
  localparam logic [4:0] BC_ADDR  = 5'h1E;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] GEN_RESET = 16'h8000;
  localparam logic [15:0] ACT_RESET = 16'h0000;
  localparam logic [15:0] BC_RESET  = 16'h0000;
  // ****************************************
  // field positions
  // ****************************************
  localparam int SLEW_HI   = 15;
  localparam int SLEW_LO   = 13;
  localparam int RETRY_BIT = 12;
  localparam int SKIP1_BIT = 11;
  localparam int SKIP2_BIT = 10;
  localparam int TEST_HI   = 9;
  localparam int TEST_LO   = 8;
  localparam int FCLR_BIT  = 15;
  localparam int LOCK_BIT  = 14;
  localparam int DRV1_HI   = 13;
  localparam int DRV1_LO   = 11;
  localparam int DRV2_HI   = 10;
  localparam int DRV2_LO   = 8;
  localparam int RSTRT_BIT = 14;
  localparam int FORCE_BIT = 13;
  localparam int FADR_HI   = 12;
  localparam int FADR_LO   = 11;
  localparam int STEP_HI   = 10;
  localparam int STEP_LO   = 8;
  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0] TEST_FAULT_LOW = 2'h1;
  localparam logic [1:0] TEST_TIMEOUT   = 2'h2;
  localparam logic [1:0] TEST_CLOCK     = 2'h3;
  localparam logic [2:0] DRV_REGULATE   = 3'h2;
  localparam logic [2:0] STEP_SHUT      = 3'h4;
  localparam logic [7:0] TARGET_MAX     = 8'hFF;
  localparam logic [7:0] CRC_POLY       = 8'h2F;
  localparam logic [7:0] CRC_INIT       = 8'hFF;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS      = 100;
  localparam int TEST_CLK_PERIOD_NS = 100000;
  localparam int TEST_HALF_CYC      = TEST_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [9:0] TEST_HALF_LAST = 10'(TEST_HALF_CYC - 1);
endpackage

// File: tb/scr_host_model.sv
`timescale 1ns/10ps
// ****************************************
// spi host frame source
// ****************************************
module scr_host_model (
  // clock
  input  wire logic        ref_clk,
  // frame
  output logic             frame_valid,
  output logic             frame_write,
  output logic [4:0]       frame_addr,
  output logic [1:0]       frame_node,
  output logic [15:0]      frame_payload,
  output logic [7:0]       frame_crc
);
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h2F) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  initial begin
    frame_valid   = 1'b0;
    frame_write   = 1'b0;
    frame_addr    = 5'h00;
    frame_node    = 2'h0;
    frame_payload = 16'h0000;
    frame_crc     = 8'h00;
  end
  // one whole frame per call
  task automatic send(input logic w, input logic [4:0] a, input logic [1:0] n, input logic [15:0] p,
                      input logic bad);
    @(negedge ref_clk);
    frame_valid   = 1'b1;
    frame_write   = w;
    frame_addr    = a;
    frame_node    = n;
    frame_payload = p;
    frame_crc     = crc8(p) ^ {7'h00, bad};
    @(negedge ref_clk);
    frame_valid   = 1'b0;
    frame_payload = ~p;
    frame_crc     = ~frame_crc;
  endtask
endmodule

// File: tb/tb_solenoid_command_registers.sv
`timescale 1ns/10ps
module tb_solenoid_command_registers;
  logic             ref_clk, reset, frame_valid, frame_write, read_valid, sdo_drive_en, spi_error;
  logic [4:0]       frame_addr;
  logic [1:0]       frame_node, node_address, forced_address_value, out_enable, out_regulate, out_freq_mode;
  logic [15:0]      frame_payload, read_data;
  logic [7:0]       frame_crc;
  logic             in_standby, second_init_state, address_error_flag, address_restart_flag;
  logic             out1_drive_mode_sel, out2_drive_mode_sel, retry_delay_skip, out1_peak_skip, out2_peak_skip;
  logic             fault_pin_n_force_low, test_timeout_force, test_clk_out, fault_clear, config_lock;
  logic             address_restart, address_force, target_load;
  logic [2:0]       output_slew_select;
  logic [1:0][7:0]  peak_target, hold_target, peak_target_new, hold_target_new;
  logic [1:0][6:0]  out_duty_pct;
  logic [1:0][4:0]  pwm_centre_freq;
  int               fails, check_count, n;
  localparam logic [6:0] DUTY [8] = '{7'h00, 7'h00, 7'h00, 7'h64, 7'h4B, 7'h32, 7'h19, 7'h00};
  localparam logic [4:0] FREQ [8] = '{5'h00, 5'h00, 5'h14, 5'h12, 5'h10, 5'h0E, 5'h0C, 5'h0A};
  scr_host_model scr_host_model_inst (.ref_clk, .frame_valid, .frame_write, .frame_addr, .frame_node,
                                      .frame_payload, .frame_crc);
  scr_command_regs scr_command_regs_inst (.ref_clk, .reset, .frame_valid, .frame_write, .frame_addr,
    .frame_node, .frame_payload, .frame_crc, .read_data, .read_valid, .sdo_drive_en, .spi_error, .in_standby,
    .second_init_state, .node_address, .address_error_flag, .address_restart_flag, .out1_drive_mode_sel,
    .out2_drive_mode_sel, .peak_target, .hold_target, .output_slew_select, .retry_delay_skip, .out1_peak_skip,
    .out2_peak_skip, .fault_pin_n_force_low, .test_timeout_force, .test_clk_out, .fault_clear, .config_lock,
    .address_restart, .address_force, .forced_address_value, .out_enable, .out_regulate, .out_freq_mode,
    .out_duty_pct, .pwm_centre_freq, .target_load, .peak_target_new, .hold_target_new);
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] p);
    scr_host_model_inst.send(1'b1, a, 2'h1, p, 1'b0);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    scr_host_model_inst.send(1'b0, a, 2'h1, 16'h0000, 1'b0);
    chk("read_valid", 16'h0001, {15'h0000, read_valid});
    chk("read_data", e, read_data);
  endtask
  function automatic logic [7:0] step_of(input logic [7:0] t, input logic [2:0] c);
    int d;
    d = 16 << (c[1:0] - 2'h1);
    if (c[2]) return (t < d) ? 8'h00 : 8'(t - d);
    return (t + d > 255) ? 8'hFF : 8'(t + d);
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // clock, watchdog
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    reset = 1'b1;
    in_standby = 1'b0;
    second_init_state = 1'b0;
    node_address = 2'h2;
    address_error_flag = 1'b0;
    address_restart_flag = 1'b0;
    out1_drive_mode_sel = 1'b0;
    out2_drive_mode_sel = 1'b0;
    peak_target = {8'hF8, 8'h20};
    hold_target = {8'h08, 8'h40};
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    rd(scr_pkg::GEN_ADDR, scr_pkg::GEN_RESET);
    rd(scr_pkg::ACT_ADDR, 16'h0000);
    chk("sdo", 16'h0000, {15'h0000, sdo_drive_en});
    rd(scr_pkg::BC_ADDR, 16'h0000);
    chk("slew", 16'h0004, {13'h0000, output_slew_select});
    wr(5'h1C, 16'hE300);
    chk("slew", 16'h0007, {13'h0000, output_slew_select});
    rd(5'h1C, 16'hE000);
    scr_host_model_inst.send(1'b1, 5'h1C, 2'h0, 16'h1C00, 1'b1);
    chk("spi_error", 16'h0001, {15'h0000, spi_error});
    rd(5'h1C, 16'hE000);
    in_standby = 1'b1;
    wr(5'h1C, 16'h1D00);
    chk("skips", 16'h0007, {13'h0000, retry_delay_skip, out1_peak_skip, out2_peak_skip});
    chk("fault_low", 16'h0001, {15'h0000, fault_pin_n_force_low});
    wr(5'h1D, 16'h8000);
    chk("fault_clear", 16'h0001, {15'h0000, fault_clear});
    rd(5'h1D, 16'h0000);
    chk("fault_low", 16'h0000, {15'h0000, fault_pin_n_force_low});
    wr(5'h1C, 16'h1E00);
    chk("timeout", 16'h0001, {15'h0000, test_timeout_force});
    wr(5'h1E, 16'h8000);
    chk("fault_clear", 16'h0001, {15'h0000, fault_clear});
    rd(5'h1E, 16'h0000);
    chk("timeout", 16'h0000, {15'h0000, test_timeout_force});
    wr(5'h1C, 16'h1F00);
    n = 0;
    repeat (1000) begin
      @(negedge ref_clk);
      n += (test_clk_out === 1'b1);
    end
    chk("clk_high", 16'h01F4, 16'(n));
    wr(5'h1C, 16'h0000);
    chk("test_clk", 16'h0000, {15'h0000, test_clk_out});
    wr(5'h1D, 16'h4000);
    chk("lock", 16'h0001, {15'h0000, config_lock});
    for (int m = 0; m < 2; m++) begin
      out1_drive_mode_sel = m[0];
      out2_drive_mode_sel = m[0];
      for (int c = 0; c < 8; c++) begin
        wr(5'h1D, {2'h0, c[2:0], c[2:0], 8'h00});
        chk("enable", {14'h0000, {2{c > 1}}}, {14'h0000, out_enable});
        chk("regulate", {14'h0000, {2{m == 0 && c == 2}}}, {14'h0000, out_regulate});
        if (m == 1 && c > 1) begin
          chk("freq_mode", 16'h0003, {14'h0000, out_freq_mode});
          chk("freq", {6'h00, FREQ[c], FREQ[c]}, {6'h00, pwm_centre_freq});
          chk("duty", {2'h0, 7'h19, 7'h19}, {2'h0, out_duty_pct});
        end else if (c > 2) begin
          chk("duty", {2'h0, DUTY[c], DUTY[c]}, {2'h0, out_duty_pct});
        end
      end
    end
    out1_drive_mode_sel = 1'b0;
    out2_drive_mode_sel = 1'b0;
    wr(5'h1D, 16'h1200);
    for (int c = 1; c < 8; c++) begin
      if (c != 4) begin
        wr(5'h1E, {5'h00, c[2:0], 8'h00});
        chk("load", 16'h0001, {15'h0000, target_load});
        chk("peak", {step_of(8'hF8, c[2:0]), step_of(8'h20, c[2:0])}, peak_target_new);
        chk("hold", {step_of(8'h08, c[2:0]), step_of(8'h40, c[2:0])}, hold_target_new);
      end
    end
    wr(5'h1E, 16'h0400);
    chk("enable", 16'h0000, {14'h0000, out_enable});
    wr(5'h1D, 16'h1B00);
    chk("enable", 16'h0000, {14'h0000, out_enable});
    scr_host_model_inst.send(1'b0, 5'h1E, 2'h2, 16'h0000, 1'b0);
    chk("sdo", 16'h0001, {15'h0000, sdo_drive_en});
    chk("read_data", 16'h0400, read_data);
    wr(5'h1E, 16'h4000);
    chk("restart", 16'h0000, {15'h0000, address_restart});
    rd(5'h1E, 16'h0000);
    second_init_state = 1'b1;
    wr(5'h1E, 16'h4000);
    chk("restart", 16'h0001, {15'h0000, address_restart});
    address_error_flag = 1'b1;
    wr(5'h1E, 16'h3000);
    chk("force", 16'h0001, {15'h0000, address_force});
    chk("forced", 16'h0002, {14'h0000, forced_address_value});
    address_restart_flag = 1'b1;
    wr(5'h1E, 16'h2800);
    chk("force", 16'h0000, {15'h0000, address_force});
    wr(5'h1C, 16'h2000);
    wr(5'h1F, 16'hFF00);
    rd(5'h1F, 16'h0000);
    wr(5'h1B, 16'hFF00);
    rd(5'h1C, 16'h2000);
    stop_test();
  end
endmodule
